// file: gpc_keypad_model.sv
// Operator keypad model: presses one key at a time.
// Assumes the panel synchronises the key lines itself.
`timescale 1ns/1ps
`default_nettype none

module gpc_keypad_model #(
  parameter int HOLD = 6
) (
  // Clock and request
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] sel_i,
  // Keys and status
  output logic [6:0]      key_o,
  output logic            busy_o
);
  // Release one clock longer than the press, so the next press is a fresh edge
  int         cnt = 0;
  logic [2:0] sel = 3'h0;

  initial begin
    key_o = 7'h00;
    busy_o = 1'b0;
  end

  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      sel <= sel_i;
      busy_o <= 1'b1;
      cnt <= 0;
    end else if (busy_o) begin
      cnt <= cnt + 1;
      key_o <= (cnt < HOLD) ? (7'h01 << sel) : 7'h00;
      if (cnt == 2 * HOLD) begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule // gpc_keypad_model
`default_nettype wire

// file: gpc_map.vh
// Register map, field positions, reset values and timing counts of the
// gauge panel and setpoint relay controller. Definitions only.
`ifndef GPC_MAP_VH
`define GPC_MAP_VH

// Byte offsets on the APB register bus
`define GPC_CTRL_OFS      8'h00
`define GPC_PRESS_OFS     8'h04
`define GPC_STATUS_OFS    8'h08
`define GPC_ION_OFS       8'h0C
`define GPC_ERR_OFS       8'h10
`define GPC_LIN_OFS       8'h14
`define GPC_LEAK_OFS      8'h18
`define GPC_CURVE_OFS     8'h1C
`define GPC_GAS_OFS       8'h20
`define GPC_RLY_BASE      4'h4

// Pressure code: {biased exponent, mantissa m.m as 10..99}; zero is all 0
`define GPC_PW            13
`define GPC_MANT_MIN      8'h0A
`define GPC_MANT_MAX      8'h63
`define GPC_EXP_BIAS      5'h10
`define GPC_EXP_MAX       5'h1F
`define GPC_ONE_MICRON    13'h1A0A

// Field positions
`define GPC_PRESS_ION_BIT 16
`define GPC_RLY_HI_LSB    13
`define GPC_RLY_ST_LSB    26
`define GPC_ION_THR_LSB   4

// Reset values
`define GPC_NSTA_RST      4'hA
`define GPC_ION_RST       17'h00000
`define GPC_CURVE_RST     20'h55555

// Station and relay counts
`define GPC_NSTA_MAX      10
`define GPC_NRLY          4

// Display formats and panel modes
`define GPC_FMT_NUM       2'h0
`define GPC_FMT_NEG       2'h1
`define GPC_FMT_POS       2'h2
`define GPC_FMT_ERR       2'h3
`define GPC_UNITS_LAST    3'h4
`define GPC_MODE_INIT     2'h0
`define GPC_MODE_RUN      2'h1
`define GPC_MODE_SETUP    2'h2
`define GPC_MODE_DIAG     2'h3

// Timing
`define GPC_CLK_HZ        100000000
`define GPC_LEAK_TIME_S   15
`define GPC_LEAK_CYCLES   (`GPC_LEAK_TIME_S * `GPC_CLK_HZ)
`define GPC_INIT_TIME_MS  1000
`define GPC_INIT_CYCLES   (`GPC_INIT_TIME_MS * (`GPC_CLK_HZ / 1000))
`define GPC_DIAG_TIME_MS  2000
`define GPC_DIAG_CYCLES   (`GPC_DIAG_TIME_MS * (`GPC_CLK_HZ / 1000))
`define GPC_LEAK_SCALE    25'h00000F0
`define GPC_LEAK_FS       16'h270F
`define GPC_LEAK_FS_NEG   16'hD8F1
`define GPC_BLINK_BIT     24

`endif

// file: gpc_panel.v
// Front panel and setpoint relay controller, APB register slave.
// Assumes sensor firmware writes pressures over APB and keys are raw pins.
//
// Summary of operation
// - Relay energizes below its lower setpoint
// - Relay de-energizes above its upper setpoint
// - Between setpoints the relay keeps state
// - Four relays, each with station and pair
// - One to ten stations, arrows step station
// - Tenth station shows as letter A
// - Ion gauge off, flashing, until enabled
// - Exponent shown with minus or E
// - Thermocouple numeric above micron, ion exponential
// - Units key cycles five pressure units
// - Recorder outputs keep native sensor units
// - Leak rate shown after fifteen second wait
// - Leak rate saturates at 9999 per hour
// - Leak rate positive rising, negative falling
// - Status lamp follows its relay one clock later, except while blanked
// - Lamps blank during diagnostic and init
// - Test key leaves setup for run, or starts diagnostic from run
// - Setup shows setpoints, adjusts them unless locked
// - Gas key ignored while locked
// - Error code shown after power-up and diagnostic
// - Per-station recorder curve selectable
`timescale 1ns/1ps
`default_nettype none
`include "gpc_map.vh"

module gpc_panel #(
  parameter LEAK_CYCLES = `GPC_LEAK_CYCLES,
  parameter INIT_CYCLES = `GPC_INIT_CYCLES,
  parameter DIAG_CYCLES = `GPC_DIAG_CYCLES,
  parameter BLINK_BIT   = `GPC_BLINK_BIT
) (
  // Clock and reset
  input  wire        MCLK_I,
  input  wire        RST_B_I,
  // APB slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // Keypad and setup lock switch, high when pressed or locked
  input  wire        TEST_OPERATE_KEY_I,
  input  wire        SETUP_KEY_I,
  input  wire        GAS_TYPE_KEY_I,
  input  wire        UP_KEY_I,
  input  wire        DOWN_KEY_I,
  input  wire        UNITS_KEY_I,
  input  wire        LEAK_RATE_KEY_I,
  input  wire        SETUP_LOCK_I,
  // Display
  output reg  [3:0]  DISP_STATION_O,
  output reg  [7:0]  DISP_MANT_O,
  output reg  [4:0]  DISP_EXP_O,
  output reg  [1:0]  DISP_FMT_O,
  output reg  [2:0]  DISP_UNITS_O,
  output reg         DISP_OFF_FLASH_O,
  output reg  [7:0]  DISP_ERR_CODE_O,
  output reg         SETUP_MODE_O,
  output reg  [2:0]  SETUP_ITEM_O,
  output reg         GAS_ALT_O,
  output reg         ARGON_INDICATOR_O,
  output reg         HELIUM_INDICATOR_O,
  output reg         LEAK_SHOW_O,
  output reg  [15:0] LEAK_RATE_O,
  // Relays, lamps, ion gauge supply
  output wire [3:0]  RELAY_O,
  output reg  [3:0]  RELAY_LAMP_O,
  output reg         ION_HV_O,
  // Recorder output scan
  output reg  [3:0]  REC_IDX_O,
  output reg  [12:0] REC_CODE_O,
  output reg  [1:0]  REC_CURVE_O
);

  localparam PW = `GPC_PW;

  // One step of a setpoint along the pressure code, saturating at both ends
  function [PW-1:0] step;
    input [PW-1:0] c;
    input          up;
    begin
      if (up) begin
        if (c == {PW{1'b0}})
          step = {5'h00, `GPC_MANT_MIN};
        else if (c[7:0] < `GPC_MANT_MAX)
          step = {c[12:8], c[7:0] + 8'h01};
        else if (c[12:8] == `GPC_EXP_MAX)
          step = c;
        else
          step = {c[12:8] + 5'h01, `GPC_MANT_MIN};
      end else begin
        if (c == {PW{1'b0}})
          step = c;
        else if (c[7:0] > `GPC_MANT_MIN)
          step = {c[12:8], c[7:0] - 8'h01};
        else if (c[12:8] == 5'h00)
          step = {PW{1'b0}};
        else
          step = {c[12:8] - 5'h01, `GPC_MANT_MAX};
      end
    end
  endfunction

  // Key synchroniser: a change counts once stages two and three agree
  wire [7:0] keys_raw = {SETUP_LOCK_I, LEAK_RATE_KEY_I, UNITS_KEY_I, DOWN_KEY_I,
                         UP_KEY_I, GAS_TYPE_KEY_I, SETUP_KEY_I, TEST_OPERATE_KEY_I};
  reg  [7:0] ks1;
  reg  [7:0] ks2;
  reg  [7:0] ks3;
  reg  [7:0] kst;
  wire [7:0] next_kst = (~(ks2 ^ ks3) & ks2) | ((ks2 ^ ks3) & kst);
  wire [6:0] press_ev = next_kst[6:0] & ~kst[6:0];
  wire       locked   = kst[7];

  always @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ks1 <= 8'h00;
      ks2 <= 8'h00;
      ks3 <= 8'h00;
      kst <= 8'h00;
    end else begin
      ks1 <= keys_raw;
      ks2 <= ks1;
      ks3 <= ks2;
      kst <= next_kst;
    end
  end

  // Register state
  reg [PW-1:0] press [0:`GPC_NSTA_MAX-1];
  reg [9:0]    press_ok;
  reg [9:0]    ion_type;
  reg [PW-1:0] rly_lo [0:`GPC_NRLY-1];
  reg [PW-1:0] rly_hi [0:`GPC_NRLY-1];
  reg [3:0]    rly_st [0:`GPC_NRLY-1];
  reg          run;
  reg [3:0]    nsta;
  reg [16:0]   ion_cfg;
  reg [7:0]    err_code;
  reg [15:0]   lin;
  reg [19:0]   curve;
  reg          helium;

  // Panel state
  reg [1:0]    mode;
  reg [31:0]   mode_tmr;
  reg [3:0]    station;
  reg [2:0]    units;
  reg [2:0]    item;
  reg          gas_alt;
  reg          leak_busy;
  reg [31:0]   leak_tmr;
  reg [15:0]   leak_start;
  reg [23:0]   blink;
  integer      i;

  wire apb_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  wire apb_setup = PSEL_I & ~PENABLE_I;
  wire rly_hit = PADDR_I[7:4] == `GPC_RLY_BASE;
  wire [1:0] rly_ix = PADDR_I[3:2];
  wire [1:0] item_r = item[2:1];
  wire arrows_ok = (mode == `GPC_MODE_SETUP) & ~locked;

  // Register writes and setpoint adjustment share one process
  always @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (i = 0; i < `GPC_NSTA_MAX; i = i + 1)
        press[i] <= {PW{1'b0}};
      for (i = 0; i < `GPC_NRLY; i = i + 1) begin
        rly_lo[i] <= {PW{1'b0}};
        rly_hi[i] <= {PW{1'b0}};
        rly_st[i] <= 4'h0;
      end
      press_ok <= 10'h000;
      ion_type <= 10'h000;
      run      <= 1'b0;
      nsta     <= `GPC_NSTA_RST;
      ion_cfg  <= `GPC_ION_RST;
      err_code <= 8'h00;
      lin      <= 16'h0000;
      curve    <= `GPC_CURVE_RST;
      helium   <= 1'b0;
    end else begin
      if (apb_wr) begin
        case (PADDR_I)
          `GPC_CTRL_OFS: begin
            run  <= PWDATA_I[0];
            nsta <= PWDATA_I[7:4];
          end
          `GPC_PRESS_OFS: begin
            if (PWDATA_I[31:28] < `GPC_NSTA_MAX) begin
              press[PWDATA_I[31:28]]    <= PWDATA_I[12:0];
              press_ok[PWDATA_I[31:28]] <= 1'b1;
              ion_type[PWDATA_I[31:28]] <= PWDATA_I[`GPC_PRESS_ION_BIT];
            end
          end
          `GPC_ION_OFS:   ion_cfg  <= PWDATA_I[16:0];
          `GPC_ERR_OFS:   err_code <= PWDATA_I[7:0];
          `GPC_LIN_OFS:   lin      <= PWDATA_I[15:0];
          `GPC_CURVE_OFS: curve    <= PWDATA_I[19:0];
          `GPC_GAS_OFS:   helium   <= PWDATA_I[0];
          default: begin
            if (rly_hit) begin
              rly_lo[rly_ix] <= PWDATA_I[12:0];
              rly_hi[rly_ix] <= PWDATA_I[25:13];
              rly_st[rly_ix] <= PWDATA_I[29:26];
            end
          end
        endcase
      end else if (arrows_ok & (press_ev[3] | press_ev[4])) begin
        if (item[0])
          rly_hi[item_r] <= step(rly_hi[item_r], press_ev[3]);
        else
          rly_lo[item_r] <= step(rly_lo[item_r], press_ev[3]);
      end
    end
  end

  // Panel mode, station, units, gas and leak rate
  wire [16:0] leak_diff = {1'b0, lin} - {1'b0, leak_start};
  wire [24:0] leak_full = {{8{leak_diff[16]}}, leak_diff} * `GPC_LEAK_SCALE;
  wire [3:0]  sta_last  = (nsta == 4'h0) ? 4'h0 : nsta - 4'h1;

  always @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mode        <= `GPC_MODE_INIT;
      mode_tmr    <= INIT_CYCLES[31:0];
      station     <= 4'h0;
      units       <= 3'h0;
      item        <= 3'h0;
      gas_alt     <= 1'b0;
      leak_busy   <= 1'b0;
      leak_tmr    <= 32'h00000000;
      leak_start  <= 16'h0000;
      LEAK_SHOW_O <= 1'b0;
      LEAK_RATE_O <= 16'h0000;
      blink       <= 24'h000000;
    end else begin
      blink <= blink + 24'h000001;
      case (mode)
        `GPC_MODE_INIT, `GPC_MODE_DIAG: begin
          if (mode_tmr == 32'h00000000)
            mode <= `GPC_MODE_RUN;
          else
            mode_tmr <= mode_tmr - 32'h00000001;
        end
        `GPC_MODE_RUN: begin
          if (press_ev[0]) begin
            mode     <= `GPC_MODE_DIAG;
            mode_tmr <= DIAG_CYCLES[31:0];
          end else if (press_ev[1]) begin
            mode <= `GPC_MODE_SETUP;
            item <= 3'h0;
          end else if (press_ev[3]) begin
            station <= (station >= sta_last) ? 4'h0 : station + 4'h1;
          end else if (press_ev[4]) begin
            station <= (station == 4'h0) ? sta_last : station - 4'h1;
          end
        end
        `GPC_MODE_SETUP: begin
          if (press_ev[0])
            mode <= `GPC_MODE_RUN;
          else if (press_ev[1])
            item <= item + 3'h1;
        end
        default: mode <= `GPC_MODE_INIT;
      endcase
      if (press_ev[5])
        units <= (units == `GPC_UNITS_LAST) ? 3'h0 : units + 3'h1;
      if (press_ev[2] & ~locked)
        gas_alt <= ~gas_alt;
      if (press_ev[6]) begin
        leak_busy   <= 1'b1;
        leak_tmr    <= LEAK_CYCLES[31:0];
        leak_start  <= lin;
        LEAK_SHOW_O <= 1'b0;
      end else if (leak_busy) begin
        if (leak_tmr == 32'h00000000) begin
          leak_busy   <= 1'b0;
          LEAK_SHOW_O <= 1'b1;
          if ($signed(leak_full) > $signed({9'h000, `GPC_LEAK_FS}))
            LEAK_RATE_O <= `GPC_LEAK_FS;
          else if ($signed(leak_full) < $signed({9'h1FF, `GPC_LEAK_FS_NEG}))
            LEAK_RATE_O <= `GPC_LEAK_FS_NEG;
          else
            LEAK_RATE_O <= leak_full[15:0];
        end else begin
          leak_tmr <= leak_tmr - 32'h00000001;
        end
      end
    end
  end

  // Setpoint relays
  wire [3:0] rly_q;
  genvar g;
  generate
    for (g = 0; g < `GPC_NRLY; g = g + 1) begin : g_rly
      wire ok = (rly_st[g] < `GPC_NSTA_MAX) && press_ok[rly_st[g]] && run &&
                (mode != `GPC_MODE_INIT);
      gpc_relay #(.PW(PW)) u_rly (
        .clk_i       (MCLK_I),
        .rst_b_i     (RST_B_I),
        .en_i        (ok),
        .press_i     (press[rly_st[g]]),
        .lower_i     (rly_lo[g]),
        .upper_i     (rly_hi[g]),
        .energized_o (rly_q[g])
      );
    end
  endgenerate
  assign RELAY_O = rly_q;

  // Display, lamps and recorder scan
  wire [3:0]    ion_st   = ion_cfg[3:0];
  wire [PW-1:0] shown    = (mode == `GPC_MODE_SETUP) ?
                           (item[0] ? rly_hi[item_r] : rly_lo[item_r]) : press[station];
  wire          show_ion = ion_type[station];
  wire          blanked  = (mode == `GPC_MODE_INIT) | (mode == `GPC_MODE_DIAG);
  // Supply and OFF flash share one term, so OFF never shows beside a live supply
  wire          ion_on   = run && (ion_st < `GPC_NSTA_MAX) && press_ok[ion_st] &&
                           (press[ion_st] < ion_cfg[16:4]);

  always @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DISP_STATION_O     <= 4'h1;
      DISP_MANT_O        <= 8'h00;
      DISP_EXP_O         <= 5'h00;
      DISP_FMT_O         <= `GPC_FMT_ERR;
      DISP_UNITS_O       <= 3'h0;
      DISP_OFF_FLASH_O   <= 1'b0;
      DISP_ERR_CODE_O    <= 8'h00;
      SETUP_MODE_O       <= 1'b0;
      SETUP_ITEM_O       <= 3'h0;
      GAS_ALT_O          <= 1'b0;
      ARGON_INDICATOR_O  <= 1'b0;
      HELIUM_INDICATOR_O <= 1'b0;
      RELAY_LAMP_O       <= 4'h0;
      ION_HV_O           <= 1'b0;
      REC_IDX_O          <= 4'h0;
      REC_CODE_O         <= 13'h0000;
      REC_CURVE_O        <= 2'h0;
    end else begin
      // Station 10 is code A, so the digit code is just the number
      DISP_STATION_O <= station + 4'h1;
      DISP_MANT_O    <= shown[7:0];
      DISP_UNITS_O   <= units;
      DISP_ERR_CODE_O <= err_code;
      SETUP_MODE_O   <= mode == `GPC_MODE_SETUP;
      SETUP_ITEM_O   <= item;
      GAS_ALT_O      <= gas_alt;
      ARGON_INDICATOR_O  <= gas_alt & ~helium & blink[BLINK_BIT-1];
      HELIUM_INDICATOR_O <= gas_alt & helium & blink[BLINK_BIT-1];
      if (blanked) begin
        DISP_FMT_O <= `GPC_FMT_ERR;
        DISP_EXP_O <= 5'h00;
      end else if (!show_ion && shown >= `GPC_ONE_MICRON) begin
        DISP_FMT_O <= `GPC_FMT_NUM;
        DISP_EXP_O <= shown[12:8];
      end else if (shown[12:8] < `GPC_EXP_BIAS) begin
        DISP_FMT_O <= `GPC_FMT_NEG;
        DISP_EXP_O <= `GPC_EXP_BIAS - shown[12:8];
      end else begin
        DISP_FMT_O <= `GPC_FMT_POS;
        DISP_EXP_O <= shown[12:8] - `GPC_EXP_BIAS;
      end
      // The controlling thermocouple must read below its threshold first
      ION_HV_O <= ion_on;
      DISP_OFF_FLASH_O <= show_ion & ~ion_on & blink[BLINK_BIT-1];
      RELAY_LAMP_O <= blanked ? 4'h0 : rly_q;
      // Recorder codes ignore the display unit so they never jump
      REC_IDX_O   <= (REC_IDX_O >= 4'h9) ? 4'h0 : REC_IDX_O + 4'h1;
      REC_CODE_O  <= press[REC_IDX_O];
      REC_CURVE_O <= curve[REC_IDX_O*2 +: 2];
    end
  end

  // APB: no wait states, read data captured in the setup cycle
  reg [31:0] rd_mux;
  reg        rd_err;
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (PADDR_I)
      `GPC_CTRL_OFS:   rd_mux = {24'h000000, nsta, 3'h0, run};
      `GPC_PRESS_OFS:  rd_mux = {22'h000000, press_ok};
      `GPC_STATUS_OFS: rd_mux = {12'h000, blanked, locked, LEAK_SHOW_O, ION_HV_O,
                                 gas_alt, units, station, 2'h0, mode, rly_q};
      `GPC_ION_OFS:    rd_mux = {15'h0000, ion_cfg};
      `GPC_ERR_OFS:    rd_mux = {24'h000000, err_code};
      `GPC_LIN_OFS:    rd_mux = {16'h0000, lin};
      `GPC_LEAK_OFS:   rd_mux = {15'h0000, LEAK_SHOW_O, LEAK_RATE_O};
      `GPC_CURVE_OFS:  rd_mux = {12'h000, curve};
      `GPC_GAS_OFS:    rd_mux = {31'h00000000, helium};
      default: begin
        if (rly_hit)
          rd_mux = {2'h0, rly_st[rly_ix], rly_hi[rly_ix], rly_lo[rly_ix]};
        else
          rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PRDATA_O  <= 32'h00000000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= apb_setup;
      PSLVERR_O <= apb_setup & rd_err;
      if (apb_setup)
        PRDATA_O <= PWRITE_I ? 32'h00000000 : rd_mux;
    end
  end

endmodule // gpc_panel
`default_nettype wire

// file: gpc_panel_monitor.sv
// Pin-level checks on the panel controller.
// Assumes it is bound to gpc_panel and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_map.vh"

module gpc_panel_monitor (
  // Clock, reset and bus
  input wire logic        MCLK_I,
  input wire logic        RST_B_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // Display, relays and gauge
  input wire logic [3:0]  DISP_STATION_O,
  input wire logic [1:0]  DISP_FMT_O,
  input wire logic [2:0]  DISP_UNITS_O,
  input wire logic        DISP_OFF_FLASH_O,
  input wire logic        ION_HV_O,
  input wire logic        LEAK_SHOW_O,
  input wire logic [15:0] LEAK_RATE_O,
  input wire logic [3:0]  RELAY_O,
  input wire logic [3:0]  RELAY_LAMP_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  property p_ready_after_setup;
    PSEL_I && !PENABLE_I |=> PREADY_O;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_pulse;
    PREADY_O |=> !PREADY_O;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_with_ready;
    PSLVERR_O |-> PREADY_O;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_relays_off_at_start;
    $rose(RST_B_I) |-> (RELAY_O == 4'h0) [*8];
  endproperty
  a_relays_off_at_start: assert property (p_relays_off_at_start) else $error("relay on after reset");
  property p_lamp_follows;
    |RELAY_LAMP_O |-> RELAY_LAMP_O == $past(RELAY_O);
  endproperty
  a_lamp_follows: assert property (p_lamp_follows) else $error("lamp differs from relay");
  property p_lamp_blank;
    DISP_FMT_O == `GPC_FMT_ERR && $past(DISP_FMT_O) == `GPC_FMT_ERR |-> RELAY_LAMP_O == 4'h0;
  endproperty
  a_lamp_blank: assert property (p_lamp_blank) else $error("lamp lit while blanked");
  property p_station_range;
    DISP_STATION_O >= 4'h1 && DISP_STATION_O <= 4'hA;
  endproperty
  a_station_range: assert property (p_station_range) else $error("station out of range");
  property p_units_step;
    $changed(DISP_UNITS_O) |->
      DISP_UNITS_O == (($past(DISP_UNITS_O) == `GPC_UNITS_LAST) ? 3'h0 : $past(DISP_UNITS_O) + 3'h1);
  endproperty
  a_units_step: assert property (p_units_step) else $error("units skipped");
  property p_leak_sat;
    LEAK_SHOW_O |-> $signed(LEAK_RATE_O) <= $signed(`GPC_LEAK_FS)
                 && $signed(LEAK_RATE_O) >= $signed(`GPC_LEAK_FS_NEG);
  endproperty
  a_leak_sat: assert property (p_leak_sat) else $error("leak rate beyond full scale");
  property p_off_flash;
    DISP_OFF_FLASH_O |-> !ION_HV_O;
  endproperty
  a_off_flash: assert property (p_off_flash) else $error("off flash with high voltage on");
endmodule // gpc_panel_monitor

bind gpc_panel gpc_panel_monitor mon_u (.MCLK_I, .RST_B_I, .PSEL_I, .PENABLE_I, .PREADY_O, .PSLVERR_O,
  .DISP_STATION_O, .DISP_FMT_O, .DISP_UNITS_O, .DISP_OFF_FLASH_O, .ION_HV_O, .LEAK_SHOW_O, .LEAK_RATE_O,
  .RELAY_O, .RELAY_LAMP_O);
`default_nettype wire

// file: gpc_panel_tb.sv
// Self-checking bench: register table, relays, keys, leak rate, ion gauge.
// Assumes short init, diagnostic and leak counts set as parameters.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_map.vh"

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module testbench;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        err;
  } gpc_row_t;

  logic        MCLK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, SETUP_LOCK_I, PREADY_O, PSLVERR_O;
  logic        DISP_OFF_FLASH_O, SETUP_MODE_O, GAS_ALT_O, ARGON_INDICATOR_O, HELIUM_INDICATOR_O;
  logic        LEAK_SHOW_O, ION_HV_O, kgo, kbusy, perr;
  logic [1:0]  DISP_FMT_O, REC_CURVE_O;
  logic [2:0]  DISP_UNITS_O, SETUP_ITEM_O, ksel;
  logic [3:0]  DISP_STATION_O, RELAY_O, RELAY_LAMP_O, REC_IDX_O;
  logic [4:0]  DISP_EXP_O;
  logic [6:0]  keys;
  logic [7:0]  PADDR_I, DISP_MANT_O, DISP_ERR_CODE_O;
  logic [12:0] REC_CODE_O;
  logic [15:0] LEAK_RATE_O;
  logic [31:0] PWDATA_I, PRDATA_O, prd;
  int          failures = 0, checks_done = 0, cyc = 0, n;

  gpc_row_t    rows [15] = '{
    '{1'b0, 8'h00, 32'h0, 32'hA0, 1'b0}, '{1'b0, 8'h1C, 32'h0, 32'h55555, 1'b0},
    '{1'b0, 8'h24, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h24, 32'hFFFFFFFF, 32'h0, 1'b1},
    '{1'b1, 8'h1C, 32'hE4, 32'h0, 1'b0}, '{1'b0, 8'h1C, 32'h0, 32'hE4, 1'b0},
    '{1'b1, 8'h00, 32'hA1, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'hA1, 1'b0},
    '{1'b1, 8'h40, 32'h01E64F14, 32'h0, 1'b0}, '{1'b1, 8'h44, 32'h05E64F14, 32'h0, 1'b0},
    '{1'b1, 8'h48, 32'h09E64F14, 32'h0, 1'b0}, '{1'b1, 8'h4C, 32'h0DE64F14, 32'h0, 1'b0},
    '{1'b0, 8'h4C, 32'h0, 32'h0DE64F14, 1'b0}, '{1'b1, 8'h04, 32'h10000F3C, 32'h0, 1'b0},
    '{1'b1, 8'h04, 32'h20000F3C, 32'h0, 1'b0}};
  logic [12:0] pc [4] = '{13'h0F1E, 13'h0F0A, 13'h0F1E, 13'h0F3C};
  logic [3:0]  pr [4] = '{4'h0, 4'h1, 4'h1, 4'h0};
  logic [15:0] lk [2][3] = '{'{16'h0000, 16'h000A, 16'h0960}, '{16'h0064, 16'h0000, 16'hD8F1}};

  gpc_panel #(.LEAK_CYCLES(50), .INIT_CYCLES(20), .DIAG_CYCLES(20), .BLINK_BIT(4)) dut_u (
    .MCLK_I, .RST_B_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O,
    .TEST_OPERATE_KEY_I(keys[0]), .SETUP_KEY_I(keys[1]), .GAS_TYPE_KEY_I(keys[2]), .UP_KEY_I(keys[3]),
    .DOWN_KEY_I(keys[4]), .UNITS_KEY_I(keys[5]), .LEAK_RATE_KEY_I(keys[6]), .SETUP_LOCK_I,
    .DISP_STATION_O, .DISP_MANT_O, .DISP_EXP_O, .DISP_FMT_O, .DISP_UNITS_O, .DISP_OFF_FLASH_O, .DISP_ERR_CODE_O,
    .SETUP_MODE_O, .SETUP_ITEM_O, .GAS_ALT_O, .ARGON_INDICATOR_O, .HELIUM_INDICATOR_O, .LEAK_SHOW_O,
    .LEAK_RATE_O, .RELAY_O, .RELAY_LAMP_O, .ION_HV_O, .REC_IDX_O, .REC_CODE_O, .REC_CURVE_O);
  gpc_keypad_model #(.HOLD(6)) pad_u (.clk_i(MCLK_I), .go_i(kgo), .sel_i(ksel), .key_o(keys), .busy_o(kbusy));

  initial begin
    MCLK_I = 1'b0;
    forever #5 MCLK_I = ~MCLK_I;
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic wt(input int c);
    repeat (c) @(posedge MCLK_I);
    @(negedge MCLK_I);
  endtask

  // Ready and read data are taken at the rising edge where the slave sees them
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK_I);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge MCLK_I);
    end while (PREADY_O !== 1'b1);
    prd = PRDATA_O;
    perr = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  task automatic key(input int k);
    int c;
    c = 0;
    @(posedge MCLK_I);
    ksel <= 3'(k);
    kgo <= 1'b1;
    @(posedge MCLK_I);
    kgo <= 1'b0;
    do begin
      @(negedge MCLK_I);
      c++;
    end while (kbusy !== 1'b0 && c < 50);
  endtask

  initial begin
    {RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, SETUP_LOCK_I, kgo} = 6'h00;
    {PADDR_I, PWDATA_I, ksel} = 43'h0;
    repeat (6) @(posedge MCLK_I);
    `CHK(DISP_STATION_O, 4'h1)
    `CHK(DISP_FMT_O, `GPC_FMT_ERR)
    RST_B_I <= 1'b1;
    wt(2);
    `CHK(RELAY_LAMP_O, 4'h0)
    `CHK(DISP_FMT_O, `GPC_FMT_ERR)
    wt(30);
    `CHK(RELAY_O, 4'h0)
    $display("test reset done");
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK(perr, rows[i].err)
      if (!rows[i].w) `CHK(prd, rows[i].e)
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h04, {19'h0, pc[i]});
      wt(3);
      `CHK(RELAY_O, pr[i])
      `CHK(RELAY_LAMP_O, pr[i])
    end
    $display("test relays done");
    for (int i = 1; i <= 5; i++) begin
      key(5);
      `CHK(DISP_UNITS_O, 3'(i % 5))
    end
    key(4);
    `CHK(DISP_STATION_O, 4'hA)
    key(3);
    `CHK(DISP_STATION_O, 4'h1)
    @(posedge MCLK_I) SETUP_LOCK_I <= 1'b1;
    key(2);
    `CHK(GAS_ALT_O, 1'b0)
    @(posedge MCLK_I) SETUP_LOCK_I <= 1'b0;
    key(2);
    `CHK(GAS_ALT_O, 1'b1)
    key(1);
    `CHK(SETUP_MODE_O, 1'b1)
    `CHK(SETUP_ITEM_O, 3'h0)
    @(posedge MCLK_I) SETUP_LOCK_I <= 1'b1;
    key(3);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(prd, 32'h01E64F14)
    @(posedge MCLK_I) SETUP_LOCK_I <= 1'b0;
    key(3);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(prd, 32'h01E64F15)
    // Operator runs a setpoint down to zero, then the bus restores it
    apb(1'b1, 8'h40, 32'h00000001);
    key(4);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(prd, 32'h00000000)
    apb(1'b1, 8'h40, 32'h01E64F15);
    key(0);
    `CHK(SETUP_MODE_O, 1'b0)
    $display("test keys done");
    apb(1'b1, 8'h04, 32'h00000F0A);
    apb(1'b1, 8'h10, 32'h0000005A);
    key(0);
    `CHK(DISP_FMT_O, `GPC_FMT_ERR)
    `CHK(DISP_ERR_CODE_O, 8'h5A)
    `CHK(RELAY_LAMP_O, 4'h0)
    wt(25);
    `CHK(RELAY_LAMP_O, 4'h1)
    $display("test diagnostic done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h14, {16'h0, lk[i][0]});
      key(6);
      apb(1'b1, 8'h14, {16'h0, lk[i][1]});
      @(negedge MCLK_I);
      `CHK(LEAK_SHOW_O, 1'b0)
      n = 0;
      while (LEAK_SHOW_O !== 1'b1 && n < 200) begin
        @(negedge MCLK_I);
        n++;
      end
      `CHK(LEAK_RATE_O, lk[i][2])
    end
    $display("test leak rate done");
    apb(1'b1, 8'h0C, 32'h0001F630);
    apb(1'b1, 8'h04, 32'h00011232);
    wt(3);
    `CHK({DISP_FMT_O, DISP_EXP_O, DISP_MANT_O}, {`GPC_FMT_POS, 5'h02, 8'h32})
    apb(1'b1, 8'h04, 32'h00010F0A);
    wt(3);
    `CHK({DISP_FMT_O, DISP_EXP_O, ION_HV_O}, {`GPC_FMT_NEG, 5'h01, 1'b1})
    apb(1'b1, 8'h0C, 32'h0000F140);
    apb(1'b1, 8'h04, 32'h00010F3C);
    n = 0;
    while (DISP_OFF_FLASH_O !== 1'b1 && n < 40) begin
      @(negedge MCLK_I);
      n++;
    end
    `CHK({ION_HV_O, DISP_OFF_FLASH_O, ARGON_INDICATOR_O, HELIUM_INDICATOR_O}, 4'h6)
    while (REC_IDX_O !== 4'h2) @(negedge MCLK_I);
    `CHK({REC_CODE_O, REC_CURVE_O}, {13'h0F3C, 2'h1})
    $display("test ion gauge done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire

// file: gpc_relay.v
// One hysteretic setpoint relay.
// Assumes pressure and setpoints share the monotonic pressure code.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_map.vh"

module gpc_relay #(
  parameter PW = `GPC_PW
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_b_i,
  // Comparison inputs
  input  wire          en_i,
  input  wire [PW-1:0] press_i,
  input  wire [PW-1:0] lower_i,
  input  wire [PW-1:0] upper_i,
  // Relay drive
  output reg           energized_o
);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      energized_o <= 1'b0;
    end else if (!en_i) begin
      energized_o <= 1'b0;
    end else if (press_i < lower_i) begin
      energized_o <= 1'b1;
    end else if (press_i > upper_i) begin
      energized_o <= 1'b0;
    end
  end

endmodule // gpc_relay
`default_nettype wire
